// ---- rtl/pmc_consts.svh ----
// Register offsets, field positions, reset values, source encodings and divider codes for the match counter
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// ==========================================
// Register byte offsets
`define PMC_OFS_STATUS_AND_CONTROL 12'h000
`define PMC_OFS_CURRENT_COUNT      12'h004
`define PMC_OFS_MATCH_LIMIT        12'h008
`define PMC_OFS_DMA_CONTROL        12'h00c
`define PMC_OFS_MODE_STATUS        12'h010

// ==========================================
// Field positions
`define PMC_BIT_FLAG        7
`define PMC_BIT_SRC_HI      6
`define PMC_BIT_SRC_LO      5
`define PMC_BIT_REQ_EN      4
`define PMC_BIT_DIV_HI      3
`define PMC_BIT_DIV_LO      0
`define PMC_BIT_DMA_EN      7

// ==========================================
// Reset values
`define PMC_RST_BYTE        8'h00
`define PMC_RST_SRC         2'h0
`define PMC_RST_DIV         4'h0
`define PMC_RST_PRESCALE    20'h00000

// ==========================================
// Source encodings
`define PMC_SRC_LPO         2'h0
`define PMC_SRC_EXT         2'h1

// ==========================================
// Divider codes
`define PMC_DIV_OFF         4'h0
`define PMC_DIV_MIXED_BIT   3

`endif

// ---- rtl/pmc_pkg.sv ----
// Types shared by the periodic match counter
package pmc_pkg;
	typedef enum logic [1:0] {
		PMC_RUN_NORMAL,
		PMC_RUN_WAIT,
		PMC_RUN_STOP_SHALLOW,
		PMC_RUN_STOP_DEEP
	} pmc_power_mode_t;
endpackage

// ---- rtl/pmc_periodic_match_counter.sv ----
// Periodic match counter: prescaler, 8-bit up-counter, match flag and APB register slave
// Summary of operation
// - One 8-bit up-counter advanced by prescaler, compared against match limit.
// - Match sets sticky flag; reads 1 after match; reset clears it.
// - Writing 0 to flag does nothing; writing 1 clears flag and request.
// - DMA transfer-done clears the flag and its pending request.
// - Source select 00 low-power osc, 01 external, 1x internal; reset clears.
// - Changing source select clears prescaler and count.
// - Request enable with DMA routing gives DMA request while flag set.
// - Request enable without DMA routing gives interrupt while flag set.
// - Request enable low gives no requests; reset clears it.
// - Divider select picks ratio; change clears prescaler and count; reset clears.
// - Divider 0 stops prescaler; 1-7 binary ratios; 8-15 mixed ratios.
// - Debug freezes counting; resumes from frozen value if settings unchanged.
// - Counter runs in wait; interrupt or DMA request wakes processor.
// - Counter runs in both stop modes; only interrupt wakes from stop.
// - Low-power osc works in both stops; other sources only shallow stop.
// - DMA routing enable is read/write bit 7 of DMA control; reset clears.
// - Ratio depends on divider select and low bit of source select.
// - Writing match limit clears prescaler and count; limit 0 flags every tick.
// - On match count wraps to zero; flag sets on match-to-zero step.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pmc_consts.svh"

module pmc_periodic_match_counter #(
	parameter int PRESCALE_W = 20
) (
	// APB slave
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Clock gate and power state
	input  wire logic                   bus_clock_gate_bit,
	input  wire logic                   debug_active,
	input  wire pmc_pkg::pmc_power_mode_t power_mode,
	// Source clocks, asynchronous to pclk
	input  wire logic                   low_power_oscillator,
	input  wire logic                   external_reference_clock,
	input  wire logic                   internal_reference_clock,
	// DMA engine
	input  wire logic                   dma_done,
	output logic                        dma_request,
	// Interrupt and wakeup
	output logic                        irq_request,
	output logic                        wakeup_request
);

	// ==========================================
	// Source synchronisers and edge detect
	// Two flops per source, a third flop only for edge detection
	logic [2:0] src_meta_q;
	logic [2:0] src_sync_q;
	logic [2:0] src_prev_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_meta_q <= 3'h0;
			src_sync_q <= 3'h0;
			src_prev_q <= 3'h0;
		end else begin
			src_meta_q <= {internal_reference_clock, external_reference_clock,
				low_power_oscillator};
			src_sync_q <= src_meta_q;
			src_prev_q <= src_sync_q;
		end
	end

	// ==========================================
	// Registers
	logic                  flag_q;
	logic [1:0]            source_select_q;
	logic                  request_enable_q;
	logic [3:0]            divider_select_q;
	logic                  dma_routing_enable_q;
	logic [7:0]            match_limit_q;
	logic [7:0]            current_count_q;
	logic [PRESCALE_W-1:0] prescale_q;

	logic       wr_en;
	logic       rd_en;
	logic       wr_ctl;
	logic       wr_dma;
	logic       wr_lim;
	logic       addr_ok;
	logic       restart;
	logic       src_edge;
	logic       src_usable;
	logic       tick;
	logic       match;
	logic [PRESCALE_W-1:0] ratio;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction

	assign wr_en   = psel && penable && pwrite && pstrb[0];
	assign rd_en   = psel && !pwrite;

	// Decode of the five mapped words
	assign addr_ok = hit(paddr, `PMC_OFS_STATUS_AND_CONTROL) ||
		hit(paddr, `PMC_OFS_CURRENT_COUNT) ||
		hit(paddr, `PMC_OFS_MATCH_LIMIT) ||
		hit(paddr, `PMC_OFS_DMA_CONTROL) ||
		hit(paddr, `PMC_OFS_MODE_STATUS);

	// Writes need the low byte strobe
	assign wr_ctl  = wr_en && hit(paddr, `PMC_OFS_STATUS_AND_CONTROL);
	assign wr_dma  = wr_en && hit(paddr, `PMC_OFS_DMA_CONTROL);
	assign wr_lim  = wr_en && hit(paddr, `PMC_OFS_MATCH_LIMIT);

	// Restart on changed source/divider or any limit write
	assign restart = wr_lim || (wr_ctl && (
		pwdata[`PMC_BIT_SRC_HI:`PMC_BIT_SRC_LO] != source_select_q ||
		pwdata[`PMC_BIT_DIV_HI:`PMC_BIT_DIV_LO] != divider_select_q));

	// ==========================================
	// Source choice and stop-mode availability
	always_comb begin
		case (source_select_q)
			`PMC_SRC_LPO: src_edge = src_sync_q[0] && !src_prev_q[0];
			`PMC_SRC_EXT: src_edge = src_sync_q[1] && !src_prev_q[1];
			default:      src_edge = src_sync_q[2] && !src_prev_q[2];
		endcase
	end

	// Reference clocks are gated off in deep stop
	assign src_usable = (power_mode != pmc_pkg::PMC_RUN_STOP_DEEP) ||
		(source_select_q == `PMC_SRC_LPO);

	// ==========================================
	// Divide ratio table
	function automatic logic [PRESCALE_W-1:0] div_ratio(input logic lsb,
		input logic [3:0] sel);
		logic [PRESCALE_W-1:0] r;
		r = '0;
		if (!sel[`PMC_DIV_MIXED_BIT]) begin
			case (sel[2:0])
				3'h1:    r = lsb ? PRESCALE_W'(32'h400)  : PRESCALE_W'(32'h8);
				3'h2:    r = lsb ? PRESCALE_W'(32'h800)  : PRESCALE_W'(32'h20);
				3'h3:    r = lsb ? PRESCALE_W'(32'h1000) : PRESCALE_W'(32'h40);
				3'h4:    r = lsb ? PRESCALE_W'(32'h2000) : PRESCALE_W'(32'h80);
				3'h5:    r = lsb ? PRESCALE_W'(32'h4000) : PRESCALE_W'(32'h100);
				3'h6:    r = lsb ? PRESCALE_W'(32'h8000) : PRESCALE_W'(32'h200);
				3'h7:    r = lsb ? PRESCALE_W'(32'h10000): PRESCALE_W'(32'h400);
				default: r = '0;
			endcase
		end else begin
			case (sel[2:0])
				3'h0:    r = lsb ? PRESCALE_W'(32'h3e8)  : PRESCALE_W'(32'h1);
				3'h1:    r = lsb ? PRESCALE_W'(32'h7d0)  : PRESCALE_W'(32'h2);
				3'h2:    r = lsb ? PRESCALE_W'(32'h1388) : PRESCALE_W'(32'h4);
				3'h3:    r = lsb ? PRESCALE_W'(32'h2710) : PRESCALE_W'(32'ha);
				3'h4:    r = lsb ? PRESCALE_W'(32'h4e20) : PRESCALE_W'(32'h10);
				3'h5:    r = lsb ? PRESCALE_W'(32'hc350) : PRESCALE_W'(32'h64);
				3'h6:    r = lsb ? PRESCALE_W'(32'h186a0): PRESCALE_W'(32'h1f4);
				default: r = lsb ? PRESCALE_W'(32'h30d40): PRESCALE_W'(32'h3e8);
			endcase
		end
		div_ratio = r;
	endfunction

	assign ratio = div_ratio(source_select_q[0], divider_select_q);

	// ==========================================
	// Prescaler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_q <= PRESCALE_W'(`PMC_RST_PRESCALE);
		end else if (restart) begin
			// Restart outranks the debug freeze
			prescale_q <= '0;
		end else if (divider_select_q == `PMC_DIV_OFF) begin
			prescale_q <= '0;
		end else if (src_edge && src_usable && !debug_active) begin
			if (prescale_q >= ratio - PRESCALE_W'(1)) begin
				prescale_q <= '0;
			end else begin
				prescale_q <= prescale_q + PRESCALE_W'(1);
			end
		end
	end


	// Tick on the last prescaler step; a restart cycle suppresses it
	assign tick  = (divider_select_q != `PMC_DIV_OFF) &&
		src_edge && src_usable && !debug_active && !restart &&
		(prescale_q >= ratio - PRESCALE_W'(1));
	assign match = tick && (current_count_q == match_limit_q);

	// ==========================================
	// Counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			current_count_q <= `PMC_RST_BYTE;
		end else if (restart) begin
			current_count_q <= `PMC_RST_BYTE;
		end else if (match) begin
			current_count_q <= `PMC_RST_BYTE;
		end else if (tick) begin
			current_count_q <= current_count_q + 8'h01;
		end
	end

	// ==========================================
	// Match flag
	// Set outranks both clears so no match is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else if (match) begin
			flag_q <= 1'b1;
		end else if (wr_ctl && pwdata[`PMC_BIT_FLAG]) begin
			flag_q <= 1'b0;
		end else if (dma_done && dma_request) begin
			flag_q <= 1'b0;
		end
	end

	// ==========================================
	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_select_q  <= `PMC_RST_SRC;
			request_enable_q <= 1'b0;
			divider_select_q <= `PMC_RST_DIV;
		end else if (wr_ctl) begin
			source_select_q  <= pwdata[`PMC_BIT_SRC_HI:`PMC_BIT_SRC_LO];
			request_enable_q <= pwdata[`PMC_BIT_REQ_EN];
			divider_select_q <= pwdata[`PMC_BIT_DIV_HI:`PMC_BIT_DIV_LO];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_routing_enable_q <= 1'b0;
		end else if (wr_dma) begin
			dma_routing_enable_q <= pwdata[`PMC_BIT_DMA_EN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_limit_q <= `PMC_RST_BYTE;
		end else if (wr_lim) begin
			match_limit_q <= pwdata[7:0];
		end
	end

	// ==========================================
	// Requests and wakeup
	assign dma_request = flag_q && request_enable_q && dma_routing_enable_q;
	assign irq_request = flag_q && request_enable_q && !dma_routing_enable_q;

	// DMA requests cannot wake from stop
	always_comb begin
		case (power_mode)
			pmc_pkg::PMC_RUN_WAIT:         wakeup_request = irq_request || dma_request;
			pmc_pkg::PMC_RUN_STOP_SHALLOW: wakeup_request = irq_request;
			pmc_pkg::PMC_RUN_STOP_DEEP:    wakeup_request = irq_request;
			default:                       wakeup_request = 1'b0;
		endcase
	end

	// ==========================================
	// APB read path and response
	assign pready  = 1'b1;
	// Access with the clock gate off gets a slave error, though writes still take effect
	assign pslverr = psel && penable && (!addr_ok || !bus_clock_gate_bit);

	// Read data captured in setup, held until the next read setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en && !penable) begin
			if (hit(paddr, `PMC_OFS_STATUS_AND_CONTROL)) begin
				prdata <= {24'h000000, flag_q, source_select_q, request_enable_q,
					divider_select_q};
			end else if (hit(paddr, `PMC_OFS_CURRENT_COUNT)) begin
				prdata <= {24'h000000, current_count_q};
			end else if (hit(paddr, `PMC_OFS_MATCH_LIMIT)) begin
				prdata <= {24'h000000, match_limit_q};
			end else if (hit(paddr, `PMC_OFS_DMA_CONTROL)) begin
				prdata <= {24'h000000, dma_routing_enable_q, 7'h00};
			end else if (hit(paddr, `PMC_OFS_MODE_STATUS)) begin
				prdata <= {30'h00000000, debug_active, src_usable};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

endmodule

// ---- verif/pmc_props.sv ----
// Port checker for the periodic match counter
`timescale 1ns/1ps
module pmc_props (
	// Bus
	input wire logic                     pclk,
	input wire logic                     presetn,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [11:0]              paddr,
	input wire logic [31:0]              pwdata,
	input wire logic [3:0]               pstrb,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	// System and requests
	input wire logic                     bus_clock_gate_bit,
	input wire pmc_pkg::pmc_power_mode_t power_mode,
	input wire logic                     dma_done,
	input wire logic                     dma_request,
	input wire logic                     irq_request,
	input wire logic                     wakeup_request
);
	logic mapped;
	logic rd_setup;
	logic wr_acc;
	assign mapped = paddr[1:0] == 2'h0 && paddr <= 12'h010;
	assign rd_setup = psel && !penable && !pwrite;
	assign wr_acc = psel && penable && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ========
	// Sequences
	sequence s_acc;
		psel && penable;
	endsequence
	// Flag clear that also stops the prescaler
	sequence s_clr;
		s_acc ##0 (pwrite && pstrb[0] && paddr == 12'h000 && pwdata[7] && pwdata[3:0] == 4'h0);
	endsequence
	// ========
	// Assertions
	a_req_exclusive: assert property (!(irq_request && dma_request))
		else $error("irq and dma request both high");
	a_irq_sticky: assert property (irq_request && !wr_acc |=> irq_request)
		else $error("irq request dropped without a write");
	a_dma_sticky: assert property (dma_request && !dma_done && !wr_acc |=> dma_request)
		else $error("dma request dropped without done");
	a_clear_drops: assert property (s_clr |=> !irq_request && !dma_request)
		else $error("request stays after flag clear");
	a_wake_wait: assert property (power_mode == pmc_pkg::PMC_RUN_WAIT |->
		wakeup_request == (irq_request || dma_request))
		else $error("wakeup wrong in wait");
	a_wake_stop: assert property (power_mode inside {pmc_pkg::PMC_RUN_STOP_SHALLOW,
		pmc_pkg::PMC_RUN_STOP_DEEP} |-> wakeup_request == irq_request)
		else $error("wakeup wrong in stop");
	a_wake_normal: assert property (power_mode == pmc_pkg::PMC_RUN_NORMAL |-> !wakeup_request)
		else $error("wakeup in normal mode");
	a_err_decode: assert property (s_acc |-> pready && pslverr == (!mapped || !bus_clock_gate_bit))
		else $error("slave error or ready wrong");
	a_prdata_stands: assert property (!$past(rd_setup) |-> $stable(prdata))
		else $error("read data changed outside read setup");
	a_upper_zero: assert property (prdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
endmodule

bind pmc_periodic_match_counter pmc_props pmc_props_i (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .bus_clock_gate_bit,
	.power_mode, .dma_done, .dma_request, .irq_request, .wakeup_request);

// ---- verif/pmc_far_side.sv ----
// Far-side model: DMA engine answering requests with a done pulse
`timescale 1ns/1ps
module pmc_far_side (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// DMA handshake
	input  wire logic dma_request,
	input  wire logic done_en,
	output logic      dma_done
);
	logic [1:0] wait_q;
	// Done four cycles into a request, then the count starts again while it stays high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q   <= 2'h0;
			dma_done <= 1'b0;
		end else begin
			dma_done <= dma_request && done_en && wait_q == 2'h3;
			wait_q   <= (dma_request && done_en && !dma_done) ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule

// ---- verif/pmc_periodic_match_counter_test.sv ----
// Self-checking bench for the periodic match counter
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module pmc_periodic_match_counter_test;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0]  pstrb = 4'h0;
	logic        bus_clock_gate_bit = 1'b0;
	logic        debug_active = 1'b0;
	logic        low_power_oscillator = 1'b0;
	logic        external_reference_clock = 1'b0;
	logic        internal_reference_clock = 1'b0;
	logic        done_en = 1'b0;
	pmc_pkg::pmc_power_mode_t power_mode = pmc_pkg::PMC_RUN_NORMAL;
	logic [31:0] prdata;
	logic        pready, pslverr, dma_done, dma_request, irq_request, wakeup_request;
	logic [7:0]  rd;
	logic [7:0]  held;
	logic        err;
	int          err_total = 0;
	int          checked = 0;
	logic [11:0] act_a [4] = '{12'h000, 12'h000, 12'h000, 12'h008};
	logic [7:0]  act_d [4] = '{8'h28, 8'h48, 8'h00, 8'hff};
	always #25 pclk = ~pclk;
	always #200 low_power_oscillator = ~low_power_oscillator;
	pmc_periodic_match_counter pmc_periodic_match_counter_i (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .bus_clock_gate_bit,
		.debug_active, .power_mode, .low_power_oscillator, .external_reference_clock,
		.internal_reference_clock, .dma_done, .dma_request, .irq_request, .wakeup_request);
	pmc_far_side pmc_far_side_i (.pclk, .presetn, .dma_request, .done_en, .dma_done);
	// ========
	// Tasks
	task finish_test();
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		pstrb   <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			err_total++;
			finish_test();
		end
		rd = prdata[7:0];
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rdchk(input string nm, input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		`CHK(nm, e, rd)
	endtask
	task wait_req(input logic dma, input logic lvl);
		int n;
		n = 0;
		while ((dma ? dma_request : irq_request) !== lvl && n < 3000) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 3000) begin
			err_total++;
			finish_test();
		end
		@(posedge pclk);
	endtask
	task wake_loop(input logic irq);
		for (int m = 0; m < 4; m++) begin
			power_mode <= pmc_pkg::pmc_power_mode_t'(m);
			@(negedge pclk);
			`CHK("wakeup", irq ? m != 0 : m == 1, wakeup_request)
		end
		power_mode <= pmc_pkg::PMC_RUN_NORMAL;
		@(posedge pclk);
	endtask
	// ========
	// Sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn            <= 1'b1;
		bus_clock_gate_bit <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 4; i++) begin
			rdchk("reset value", 12'(4 * i), 8'h00);
		end
		rdchk("mode status", 12'h010, 8'h01);
		apb(1'b0, 12'h014, 8'h00);
		`CHK("unmapped error", 1'b1, err)
		`CHK("unmapped data", 8'h00, rd)
		bus_clock_gate_bit <= 1'b0;
		apb(1'b0, 12'h000, 8'h00);
		`CHK("gate error", 1'b1, err)
		bus_clock_gate_bit <= 1'b1;
		$display("test registers done");
		apb(1'b1, 12'h008, 8'h03);
		apb(1'b1, 12'h000, 8'h18);
		wait_req(1'b0, 1'b1);
		`CHK("irq only", 1'b0, dma_request)
		rdchk("wrap to zero", 12'h004, 8'h00);
		rdchk("flag set", 12'h000, 8'h98);
		wake_loop(1'b1);
		apb(1'b1, 12'h000, 8'h18);
		rdchk("zero write keeps", 12'h000, 8'h98);
		apb(1'b1, 12'h000, 8'h90);
		repeat (40) @(posedge pclk);
		rdchk("cleared and off", 12'h000, 8'h10);
		rdchk("count held", 12'h004, 8'h00);
		apb(1'b1, 12'h000, 8'h08);
		repeat (48) @(posedge pclk);
		rdchk("polled flag", 12'h000, 8'h88);
		`CHK("no irq", 1'b0, irq_request)
		$display("test interrupt done");
		apb(1'b1, 12'h00c, 8'h80);
		rdchk("dma routing", 12'h00c, 8'h80);
		apb(1'b1, 12'h000, 8'h98);
		wait_req(1'b1, 1'b1);
		`CHK("dma only", 1'b0, irq_request)
		wake_loop(1'b0);
		done_en <= 1'b1;
		wait_req(1'b1, 1'b0);
		done_en <= 1'b0;
		rdchk("done clears", 12'h000, 8'h18);
		apb(1'b1, 12'h00c, 8'h00);
		$display("test dma done");
		apb(1'b1, 12'h008, 8'hff);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h000, 8'h08);
			repeat (40) @(posedge pclk);
			apb(1'b0, 12'h004, 8'h00);
			`CHK("count runs", 1'b1, rd != 8'h00)
			if (i == 3) begin
				debug_active <= 1'b1;
				@(posedge pclk);
				apb(1'b0, 12'h004, 8'h00);
				held = rd;
				repeat (40) @(posedge pclk);
				rdchk("frozen", 12'h004, held);
			end
			apb(1'b1, act_a[i], act_d[i]);
			rdchk("restart clears", 12'h004, 8'h00);
			if (i == 0) begin
				power_mode <= pmc_pkg::PMC_RUN_STOP_DEEP;
				rdchk("deep stop ref", 12'h010, 8'h00);
				power_mode <= pmc_pkg::PMC_RUN_NORMAL;
			end
		end
		debug_active <= 1'b0;
		repeat (40) @(posedge pclk);
		apb(1'b0, 12'h004, 8'h00);
		`CHK("resumes", 1'b1, rd != 8'h00)
		$display("test restarts done");
		finish_test();
	end
endmodule
